// file: include/can_retry_map.svh
`ifndef CAN_RETRY_MAP_SVH
`define CAN_RETRY_MAP_SVH

// intermission lengths in bit times
`define CAN_SPACING_NORMAL 3'h3
`define CAN_SPACING_LONG   3'h4
// saturation value of the intermission bit counter
`define CAN_IFS_CNT_MAX    3'h7
// identifier field layout (extended identifier width, standard part at the top)
`define CAN_ID_W           29
`define CAN_STD_ID_LSB     18
// reset values
`define CAN_OBJ_EN_RST     1'b0
`define CAN_RX_FLAG_RST    1'b0

`endif

// file: include/can_retry_pkg.sv
package can_retry_pkg;

    typedef enum {
        LINK_FRAME,
        LINK_SPACING
    } link_state_t;

endpackage : can_retry_pkg

// file: design/can_retry_rx_accept.sv
// Function
// - a transmit request that meets a busy bus waits for a three-bit intermission after that frame.
// - after lost arbitration with an accepting receive object, the retry follows the next three-bit intermission.
// - after lost arbitration with no accepting receive object, the retry waits a four-bit intermission.
// - a receive object joins acceptance only if enabled no later than the first DLC bit of the frame.
// - on good reception the receiving object's receive_complete_flag is set right after the sixth EOF bit.
// - object 14 has the lowest priority when several objects could accept a frame.
// - a filter-matching object other than object 14 wins over a catch-all object, which takes only frames that no such object accepts.
`timescale 1ns/10ps
`include "can_retry_map.svh"

module can_retry_rx_accept
    import can_retry_pkg::*;
#(
    parameter int OBJ_N = 15,
    parameter int ID_W  = `CAN_ID_W
) (
    input  wire logic                  clk_sys,         // system clock, 125 MHz
    input  wire logic                  rst_n,           // async reset, active low
    input  wire logic                  bit_tick,        // one pulse per nominal bit time
    input  wire logic                  sof,             // start of any frame seen on the bus
    input  wire logic                  eof_done,        // last bit of end of frame passed
    input  wire logic                  dlc_first,       // first bit of the DLC field
    input  wire logic                  eof_bit6,        // sixth bit of end of frame passed
    input  wire logic                  rx_ok,           // frame received without error
    input  wire logic [ID_W-1:0]       rx_id,           // received identifier
    input  wire logic                  rx_ide,          // received frame is extended format
    input  wire logic                  arb_lost,        // own transmission lost arbitration
    input  wire logic                  tx_req,          // a transmit object is enabled and pending
    input  wire logic [OBJ_N-1:0]      obj_en_set,      // software enables object for reception
    input  wire logic [OBJ_N-1:0]      obj_catch_all,   // object in catch-all listening setting
    input  wire logic [OBJ_N-1:0]      obj_ide,         // object expects extended format
    input  wire logic [OBJ_N*ID_W-1:0] obj_id_tag,      // identifier tags, object 0 lowest slice
    input  wire logic [OBJ_N*ID_W-1:0] obj_id_mask,     // acceptance masks, 1 = compare bit
    input  wire logic [OBJ_N-1:0]      rx_flag_clr,     // software clears receive_complete_flag
    output logic                       tx_start,        // pulse: transmission may start now
    output logic                       long_spacing,    // next retry uses four-bit spacing
    output logic [OBJ_N-1:0]           obj_rx_enabled,  // receive object enabled
    output logic [OBJ_N-1:0]           receive_complete_flag, // sticky per-object flag
    output logic                       rx_hit,          // current frame has an accepting object
    output logic [$clog2(OBJ_N)-1:0]   rx_hit_obj       // index of accepting object
);

    localparam int IDX_W = $clog2(OBJ_N);

    // refused at elaboration: the priority slices need at least two objects
    if (OBJ_N < 2 || OBJ_N > 64 || ID_W < 11 || ID_W > `CAN_ID_W) begin : g_param_check
        $error("can_retry_rx_accept: unsupported OBJ_N or ID_W");
    end

    function automatic logic id_match(input logic [ID_W-1:0] id, input logic [ID_W-1:0] tag,
                                      input logic [ID_W-1:0] mask, input logic ide,
                                      input logic want_ide);
        id_match = (((id ^ tag) & mask) == '0) && (ide == want_ide);
    endfunction : id_match

    link_state_t         link_state;
    logic [2:0]          ifs_cnt;
    logic                lost_pending;
    logic [OBJ_N-1:0]    filt_hit;
    logic [OBJ_N-1:0]    spy_hit;
    logic [OBJ_N-1:0]    en_now;
    logic                next_hit;
    logic [IDX_W-1:0]    next_idx;
    logic [2:0]          need_bits;

    // an enable set in the first DLC bit itself still counts
    assign en_now = obj_rx_enabled | obj_en_set;

    genvar g;
    generate
        for (g = 0; g < OBJ_N; g++) begin : g_obj
            assign filt_hit[g] = en_now[g] && !obj_catch_all[g] &&
                                 id_match(rx_id, obj_id_tag[g*ID_W +: ID_W], obj_id_mask[g*ID_W +: ID_W],
                                          rx_ide, obj_ide[g]);
            assign spy_hit[g]  = en_now[g] && obj_catch_all[g];
        end
    endgenerate

    // filter matches first, catch-all second; lowest index wins inside each class;
    // the last object ranks below every other one whatever its setting
    always_comb begin
        next_hit = 1'b0;
        next_idx = '0;
        if (filt_hit[OBJ_N-1] || spy_hit[OBJ_N-1]) begin
            next_hit = 1'b1;
            next_idx = IDX_W'(OBJ_N - 1);
        end
        for (int i = OBJ_N - 2; i >= 0; i--) begin
            if (spy_hit[i]) begin
                next_hit = 1'b1;
                next_idx = IDX_W'(i);
            end
        end
        for (int i = OBJ_N - 2; i >= 0; i--) begin
            if (filt_hit[i]) begin
                next_hit = 1'b1;
                next_idx = IDX_W'(i);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_hit     <= 1'b0;
            rx_hit_obj <= '0;
        end else if (dlc_first) begin
            rx_hit     <= next_hit;
            rx_hit_obj <= next_idx;
        end else if (sof) begin
            rx_hit     <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            obj_rx_enabled <= {OBJ_N{`CAN_OBJ_EN_RST}};
        end else begin
            for (int i = 0; i < OBJ_N; i++) begin
                // completion disables; a same-cycle software enable re-arms
                if (obj_en_set[i]) begin
                    obj_rx_enabled[i] <= 1'b1;
                end else if (eof_bit6 && rx_ok && rx_hit && rx_hit_obj == IDX_W'(i)) begin
                    obj_rx_enabled[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            receive_complete_flag <= {OBJ_N{`CAN_RX_FLAG_RST}};
        end else begin
            for (int i = 0; i < OBJ_N; i++) begin
                // set beats clear so a completion is never lost
                if (eof_bit6 && rx_ok && rx_hit && rx_hit_obj == IDX_W'(i)) begin
                    receive_complete_flag[i] <= 1'b1;
                end else if (rx_flag_clr[i]) begin
                    receive_complete_flag[i] <= 1'b0;
                end
            end
        end
    end

    // arbitration loss is judged at the DLC of the winning frame
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lost_pending <= 1'b0;
            long_spacing <= 1'b0;
        end else begin
            if (arb_lost) begin
                lost_pending <= 1'b1;
            end else if (dlc_first) begin
                lost_pending <= 1'b0;
            end
            if (dlc_first && (lost_pending || arb_lost)) begin
                long_spacing <= !next_hit;
            end else if (tx_start) begin
                long_spacing <= 1'b0;
            end
        end
    end

    assign need_bits = long_spacing ? `CAN_SPACING_LONG : `CAN_SPACING_NORMAL;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            link_state <= LINK_SPACING;
            ifs_cnt    <= `CAN_IFS_CNT_MAX;
        end else begin
            case (link_state)
                LINK_FRAME: begin
                    if (eof_done) begin
                        link_state <= LINK_SPACING;
                        ifs_cnt    <= '0;
                    end
                end
                LINK_SPACING: begin
                    if (sof || tx_start) begin
                        link_state <= LINK_FRAME;
                    end else if (bit_tick && ifs_cnt != `CAN_IFS_CNT_MAX) begin
                        ifs_cnt <= ifs_cnt + 3'h1;
                    end
                end
                default: begin
                    link_state <= LINK_SPACING;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_start <= 1'b0;
        end else begin
            tx_start <= tx_req && !tx_start && !sof && link_state == LINK_SPACING &&
                        ifs_cnt >= need_bits;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    logic [OBJ_N-1:0] done_vec;
    assign done_vec = (eof_bit6 && rx_ok && rx_hit) ? (OBJ_N'(1) << rx_hit_obj) : '0;

    chk_start_after_spacing: assert property (tx_start |-> $past(ifs_cnt) >= $past(need_bits))
        else $error("transmission started before intermission completed");
    chk_start_not_busy: assert property (tx_start |-> $past(link_state) == LINK_SPACING)
        else $error("transmission started while a frame was in progress");
    chk_short_retry: assert property (dlc_first && (arb_lost || lost_pending) && next_hit |=> !long_spacing)
        else $error("accepted frame after lost arbitration did not keep short spacing");
    chk_long_retry: assert property (dlc_first && lost_pending && !next_hit |=> long_spacing)
        else $error("unaccepted frame after lost arbitration did not select long spacing");
    chk_long_not_early: assert property (tx_start && $past(long_spacing) |-> $past(ifs_cnt) >= `CAN_SPACING_LONG)
        else $error("long spacing retry started after only three bits");
    chk_accept_snapshot: assert property (dlc_first |=> rx_hit == $past(next_hit))
        else $error("acceptance not captured at first DLC bit");
    chk_flag_set_eof: assert property (eof_bit6 && rx_ok && rx_hit |=>
                                       receive_complete_flag[$past(rx_hit_obj)])
        else $error("receive complete flag not set after sixth EOF bit");
    // every bit is watched, not only the lowest one
    chk_flag_only_eof: assert property ((receive_complete_flag & ~$past(receive_complete_flag)) != '0 |->
                                        $past(eof_bit6) && $past(rx_ok) && $past(rx_hit))
        else $error("receive complete flag rose without good end of frame");
    chk_filter_first: assert property (dlc_first && filt_hit[OBJ_N-2:0] != '0 |=> !obj_catch_all[rx_hit_obj])
        else $error("catch-all object took a frame that a filter accepted");
    chk_lowest_last: assert property (dlc_first && (filt_hit[OBJ_N-1] || spy_hit[OBJ_N-1]) &&
                                      ((filt_hit[OBJ_N-2:0] | spy_hit[OBJ_N-2:0]) != '0)
                                      |=> rx_hit_obj != IDX_W'(OBJ_N - 1))
        else $error("last object chosen over a higher priority object");
    chk_done_disables: assert property ((done_vec & ~obj_en_set) != '0 |=>
                                        (obj_rx_enabled & $past(done_vec & ~obj_en_set)) == '0)
        else $error("object stayed enabled after completing reception");
    chk_spy_any_id: assert property (dlc_first && (en_now & obj_catch_all) != '0 |=> rx_hit)
        else $error("enabled catch-all object did not accept the frame");

    cov_retry_long:  cover property (dlc_first && lost_pending && !next_hit ##[1:300] tx_start);
    cov_retry_short: cover property (arb_lost ##[1:300] dlc_first && next_hit);
    cov_rx_done:     cover property (eof_bit6 && rx_ok && rx_hit);
    cov_spy_take:    cover property (dlc_first && filt_hit == '0 && spy_hit != '0);

endmodule : can_retry_rx_accept

// file: testbench/can_bus_node.sv
`timescale 1ns/10ps

module can_bus_node (
    input  wire logic        clk_sys,    // system clock
    output logic             bit_tick,   // one pulse per bit time
    output logic             sof,        // frame start
    output logic             arb_lost,   // our node lost arbitration
    output logic             dlc_first,  // first dlc bit
    output logic             eof_bit6,   // sixth end-of-frame bit
    output logic             eof_done,   // frame over
    output logic             rx_ok,      // frame good
    output logic             rx_ide,     // extended format
    output logic [28:0]      rx_id       // received identifier
);
    logic [1:0] phase = 2'h0;

    initial begin
        {sof, arb_lost, dlc_first, eof_bit6, eof_done, rx_ok, rx_ide} = 7'h0;
        rx_id = 29'h0;
    end

    // bit time is four system clocks, free running like a real bit timer
    always @(posedge clk_sys) begin
        phase    <= phase + 2'h1;
        bit_tick <= (phase == 2'h3);
    end

    // events land one cycle after a tick so they never share an edge with it
    task automatic emit(input logic [4:0] ev);
        do @(negedge clk_sys); while (bit_tick !== 1'b1);
        @(posedge clk_sys) {sof, arb_lost, dlc_first, eof_bit6, eof_done} <= ev;
        @(posedge clk_sys) {sof, arb_lost, dlc_first, eof_bit6, eof_done} <= 5'h0;
    endtask : emit

    task automatic send_frame(input logic [28:0] id, input logic ide, input logic lost, input logic ok);
        @(posedge clk_sys);
        rx_id  <= id;
        rx_ide <= ide;
        emit(5'h10);
        if (lost) emit(5'h08);
        emit(5'h00);
        emit(5'h04);
        emit(5'h00);
        emit(5'h00);
        rx_ok <= ok;
        emit(5'h02);
        rx_ok <= 1'b0;
        emit(5'h01);
        // identifier no longer valid once the frame is over
        rx_id  <= ~id;
        rx_ide <= ~ide;
    endtask : send_frame
endmodule : can_bus_node

// file: testbench/tb_top.sv
`timescale 1ns/10ps

module tb_top
    import can_retry_pkg::*;
;
    localparam logic [28:0] ID_A = 29'h2940000;
    localparam logic [28:0] ID_X = 29'h1234567;
    localparam logic [28:0] STD  = 29'h1ffc0000;
    typedef struct packed { logic [28:0] id; logic ide; logic [3:0] obj; } row_t;
    row_t rows [5] = '{'{ID_A, 1'b0, 4'h2}, '{ID_X, 1'b1, 4'h5}, '{ID_X, 1'b0, 4'he},
                       '{ID_A, 1'b1, 4'he}, '{29'h0, 1'b0, 4'he}};
    logic        clk_sys, rst_n, tx_req, tx_start, long_spacing, rx_hit;
    logic        bit_tick, sof, arb_lost, dlc_first, eof_bit6, eof_done, rx_ok, rx_ide;
    logic [28:0] rx_id;
    logic [14:0] obj_en_set, obj_catch_all, obj_ide, rx_flag_clr, obj_rx_enabled, receive_complete_flag;
    logic [434:0] obj_id_tag, obj_id_mask;
    logic [3:0]  rx_hit_obj;
    int          err_total = 0;
    int          check_count = 0;
    int          ticks = 0;

    can_bus_node node_u (.clk_sys(clk_sys), .bit_tick(bit_tick), .sof(sof), .arb_lost(arb_lost),
        .dlc_first(dlc_first), .eof_bit6(eof_bit6), .eof_done(eof_done), .rx_ok(rx_ok), .rx_ide(rx_ide),
        .rx_id(rx_id));
    can_retry_rx_accept dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .bit_tick(bit_tick), .sof(sof),
        .eof_done(eof_done), .dlc_first(dlc_first), .eof_bit6(eof_bit6), .rx_ok(rx_ok), .rx_id(rx_id),
        .rx_ide(rx_ide), .arb_lost(arb_lost), .tx_req(tx_req), .obj_en_set(obj_en_set),
        .obj_catch_all(obj_catch_all), .obj_ide(obj_ide), .obj_id_tag(obj_id_tag), .obj_id_mask(obj_id_mask),
        .rx_flag_clr(rx_flag_clr), .tx_start(tx_start), .long_spacing(long_spacing),
        .obj_rx_enabled(obj_rx_enabled), .receive_complete_flag(receive_complete_flag), .rx_hit(rx_hit),
        .rx_hit_obj(rx_hit_obj));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // bit times since the last frame ended; a frame start poisons it
    always @(posedge clk_sys) begin
        if (eof_done) ticks <= 0;
        else if (sof) ticks <= 99;
        else if (bit_tick) ticks <= ticks + 1;
    end

    task automatic report_and_stop();
        if (err_total == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    task automatic chk_vec(input string name, input logic [14:0] exp, input logic [14:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_vec

    task automatic chk_cnt(input string name, input int exp, input int got);
        check_count++;
        if (got != exp) begin
            err_total++;
            $display("FAIL %s expected %0d seen %0d", name, exp, got);
        end
    endtask : chk_cnt

    task automatic sw(input logic [14:0] en, input logic [14:0] clr);
        @(posedge clk_sys) {obj_en_set, rx_flag_clr} <= {en, clr};
        @(posedge clk_sys) {obj_en_set, rx_flag_clr} <= 30'h0;
    endtask : sw

    task automatic rx_frame(input logic [28:0] id, input logic ide, input logic ok, input logic [14:0] exp);
        fork
            node_u.send_frame(id, ide, 1'b0, ok);
            begin
                do @(negedge clk_sys); while (eof_bit6 !== 1'b1);
                chk_vec("flag early", 15'h0, receive_complete_flag);
                @(negedge clk_sys);
                chk_vec("flag", exp, receive_complete_flag);
            end
        join
    endtask : rx_frame

    task automatic wait_start(input int exp);
        int n;
        n = 0;
        while (tx_start !== 1'b1 && n < 200) begin
            @(negedge clk_sys);
            n++;
        end
        chk_vec("tx_start", 15'h1, {14'h0, tx_start});
        chk_cnt("retry bits", exp, ticks);
    endtask : wait_start

    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        report_and_stop();
    end

    initial begin
        {rst_n, tx_req, obj_en_set, rx_flag_clr} = 32'h0;
        obj_catch_all = 15'h4000;
        obj_ide       = 15'h0020;
        obj_id_tag    = '0;
        obj_id_mask   = '0;
        {obj_id_tag[58+:29], obj_id_tag[145+:29], obj_id_tag[261+:29], obj_id_tag[406+:29]} = {ID_A, ID_X, ID_A, ID_X};
        {obj_id_mask[58+:29], obj_id_mask[145+:29], obj_id_mask[261+:29]} = {STD, ~29'h0, STD};
        obj_id_mask[406+:29] = ~29'h0;
        repeat (16) @(posedge clk_sys);
        chk_vec("enabled at reset", 15'h0, obj_rx_enabled);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            sw(15'h4224, 15'h0); // catch-all kept enabled, re-armed between frames
            rx_frame(rows[i].id, rows[i].ide, 1'b1, 15'h1 << rows[i].obj);
            chk_vec("hit object", {11'h0, rows[i].obj}, {11'h0, rx_hit_obj});
            chk_vec("enabled", 15'h4224 & ~(15'h1 << rows[i].obj), obj_rx_enabled);
            sw(15'h0, 15'h7fff);
        end
        sw(15'h4224, 15'h0);
        rx_frame(29'h0, 1'b0, 1'b0, 15'h0);
        chk_vec("enabled bad frame", 15'h4224, obj_rx_enabled);
        rx_frame(29'h0, 1'b0, 1'b1, 15'h4000);
        sw(15'h0, 15'h7fff);
        rx_frame(29'h0, 1'b0, 1'b1, 15'h0);
        chk_vec("hit", 15'h0, {14'h0, rx_hit});
        fork
            node_u.send_frame(29'h0, 1'b0, 1'b0, 1'b1);
            begin
                do @(negedge clk_sys); while (sof !== 1'b1);
                @(posedge clk_sys) tx_req <= 1'b1;
            end
        join
        wait_start(3);
        node_u.send_frame(29'h0, 1'b0, 1'b1, 1'b1);
        chk_vec("long spacing", 15'h1, {14'h0, long_spacing});
        wait_start(4);
        node_u.send_frame(ID_A, 1'b0, 1'b1, 1'b1);
        chk_vec("short spacing", 15'h0, {14'h0, long_spacing});
        wait_start(3);
        @(posedge clk_sys) tx_req <= 1'b0;
        sw(15'h0, 15'h7fff);
        fork
            node_u.send_frame(29'h0, 1'b0, 1'b0, 1'b1);
            begin
                do @(negedge clk_sys); while (dlc_first !== 1'b1);
                sw(15'h4000, 15'h0);
            end
        join
        chk_vec("late enable flag", 15'h0, receive_complete_flag);
        chk_vec("late enable", 15'h4000, obj_rx_enabled & 15'h4000);
        // reset in mid-run: enables drop, and an idle bus lets a pending request start at once
        @(posedge clk_sys) {rst_n, tx_req} <= 2'b01;
        @(posedge clk_sys) rst_n <= 1'b1;
        @(negedge clk_sys);
        chk_vec("enabled after reset", 15'h0, obj_rx_enabled);
        @(negedge clk_sys);
        chk_vec("start after reset", 15'h1, {14'h0, tx_start});
        report_and_stop();
    end
endmodule : tb_top
